/* hw/otp_prog_pkg.sv */
/*
 * Constants, types and pin bundle for the one-time-programmable ROM programmer.
 * Assumes a 250 MHz clock and external level shifters that turn the supply and
 * identification-voltage selects into the real programming voltages.
 */
// Notes on behaviour
// - program pulse: chip select low 50 us nominal, within 47.5 to 52.5 us.
// - before pulses: first address set, core supply 6.5V, program supply 13.0V.
// - first pass gives each address one pulse and does no verify reads.
// - then verify each word; on mismatch up to 10 extra pulses, each verified.
// - still wrong after the tenth extra pulse: device reported as failed.
// - a word that verifies moves on to the next address until all checked.
// - then both supplies to 5.0V, read every word back, give pass or fail.
// - id mode needs the id select address line at 11.5 to 12.5 volts.
`default_nettype none

package otp_prog_pkg;

    // ----------------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int ADDR_W = 18;
    localparam int CNT_W = 19;
    localparam int TIMER_W = 16;
    localparam int RETRY_W = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_STAGES = 2;
    localparam int ID_SEL_BIT = 9;          // id select address line position
    localparam int LOW_ADDR_BIT = 0;        // picks maker or type code

    // ----------------------------------------------------------------------
    // supply levels handled by the external switches, in millivolts
    // ----------------------------------------------------------------------
    localparam int CORE_PROG_MV = 6500;
    localparam int PROG_SUPPLY_MV = 13000;
    localparam int NOMINAL_MV = 5000;
    localparam int ID_MIN_MV = 11500;
    localparam int ID_MAX_MV = 12500;

    // ----------------------------------------------------------------------
    // timing, in nanoseconds as printed, and derived cycle counts
    // ----------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_PW_NS = 50000;
    localparam int T_PW_MIN_NS = 47500;
    localparam int T_PW_MAX_NS = 52500;
    localparam int T_AS_NS = 2000;
    localparam int T_OES_NS = 2000;
    localparam int T_DS_NS = 2000;
    localparam int T_DH_NS = 2000;
    localparam int T_VPS_NS = 2000;
    localparam int T_VCS_NS = 2000;
    localparam int T_OE_NS = 150;
    localparam int T_DFP_NS = 130;

    localparam int PW_NOM_CYC = T_PW_NS / CLK_PERIOD_NS;
    localparam int PW_MIN_CYC = (T_PW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PW_MAX_CYC = T_PW_MAX_NS / CLK_PERIOD_NS;
    localparam int AS_CYC = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OES_CYC = (T_OES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DS_CYC = (T_DS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DH_CYC = (T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VPS_CYC = (T_VPS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VCS_CYC = (T_VCS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OE_CYC = (T_OE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DFP_CYC = (T_DFP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // setup before a pulse covers both address and data setup
    localparam int SETUP_CYC = (AS_CYC > DS_CYC) ? AS_CYC : DS_CYC;
    // read wait covers data valid from output gate plus the pin synchroniser
    localparam int READ_CYC = OE_CYC + SYNC_STAGES + 1;

    localparam logic [RETRY_W-1:0] MAX_RETRIES = 4'hA;

    // ----------------------------------------------------------------------
    // types
    // ----------------------------------------------------------------------
    typedef enum logic [1:0] {
        PASS_PROGRAM,
        PASS_VERIFY,
        PASS_FINAL
    } pass_e;

    // every pin the programmer drives toward the ROM socket
    typedef struct packed {
        logic [ADDR_W-1:0] addr;        // address lines, bit 0 is low_address_bit
        logic [WORD_W-1:0] data;        // write data toward the ROM
        logic data_oe_n;                // low while the programmer drives data
        logic chip_select_n;            // program pulse strobe, active low
        logic output_gate_n;            // read output gate, active low
        logic core_supply_high;         // 1: core at 6.5V, 0: core at 5.0V
        logic prog_supply_high;         // 1: program supply 13.0V, 0: 5.0V
        logic id_voltage_on;            // 1: id_select_address_line at id voltage
    } otp_pins_s;

    typedef struct packed {
        logic busy;
        logic done;                     // one-cycle pulse at end of a run
        logic passed;
        logic failed;
        pass_e phase;
        logic [ADDR_W-1:0] fail_addr;
        logic [RETRY_W-1:0] retries;
    } prog_status_s;

    localparam otp_pins_s PINS_RESET = '{
        addr: '0, data: '0, data_oe_n: 1'b1, chip_select_n: 1'b1,
        output_gate_n: 1'b1, core_supply_high: 1'b0, prog_supply_high: 1'b0,
        id_voltage_on: 1'b0};

    localparam prog_status_s STATUS_RESET = '{
        busy: 1'b0, done: 1'b0, passed: 1'b0, failed: 1'b0,
        phase: PASS_PROGRAM, fail_addr: '0, retries: '0};

endpackage : otp_prog_pkg

`default_nettype wire

/* hw/word_fifo.sv */
/*
 * Small synchronous FIFO in flip-flops with valid/ready on both sides.
 * Assumes one clock; full and empty are registered so ready and valid
 * leave the module straight from flip-flops.
 */
`default_nettype none

module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,                   // core clock
    input wire logic reset,                 // asynchronous, active high
    input wire logic in_valid,              // source offers a word
    input wire logic [WIDTH-1:0] in_data,   // offered word
    output logic in_ready,                  // room for a word
    output logic out_valid,                 // a word is waiting
    output logic [WIDTH-1:0] out_data,      // oldest word
    input wire logic out_ready              // sink takes the word
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // ----------------------------------------------------------------------
    // occupancy
    // ----------------------------------------------------------------------
    assign next_count = count + CNT_W'(push) - CNT_W'(pop);
    assign out_data = store[rd_ptr];

    // pointers and flags; flags come from next_count so they are never stale
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wr_ptr <= push ? ((wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= pop ? ((rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1) : rd_ptr;
            count <= next_count;
            in_ready <= (next_count != FULL_COUNT);
            out_valid <= (next_count != '0);
        end
    end

    // storage has no reset; contents are only read behind out_valid
    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

endmodule : word_fifo

`default_nettype wire

/* hw/otp_programmer.sv */
/*
 * Programmer for a one-time-programmable word ROM: supply sequencing, program
 * pulses, verify and re-pulse loop, final read-back and identification reads.
 * Assumes the source streams the image words in address order once for each
 * of the three passes, and external switches turn the selects into voltages.
 */
`default_nettype none

module otp_programmer
    import otp_prog_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = PW_NOM_CYC   // program pulse length in clocks
) (
    input wire logic clk,                      // 250 MHz core clock
    input wire logic reset,                    // asynchronous, active high
    input wire logic start,                    // pulse: begin a programming run
    input wire logic [CNT_W-1:0] word_count,   // words to program, from address 0
    input wire logic id_start,                 // pulse: read an id code
    input wire logic id_sel,                   // 0 maker code, 1 type code
    input wire logic src_valid,                // image word offered
    input wire logic [WORD_W-1:0] src_data,    // image word
    output logic src_ready,                    // image fifo has room
    input wire logic [WORD_W-1:0] rom_data,    // ROM data pins, asynchronous
    output otp_pins_s pins,                    // every pin toward the ROM
    output prog_status_s status,               // run progress and verdict
    output logic [WORD_W-1:0] id_code,         // last id word read
    output logic id_valid,                     // pulse: id_code updated
    output logic id_match                      // upper and lower id bytes agree
);
    typedef enum logic [3:0] {
        S_IDLE, S_CORE_UP, S_FETCH, S_SETUP, S_PULSE, S_HOLD, S_READ_SETUP,
        S_READ, S_FLOAT, S_VPP_DOWN, S_CORE_DOWN, S_ID_SETUP, S_ID_READ, S_ID_END
    } state_e;

    localparam logic [TIMER_W-1:0] SETUP_LOAD = TIMER_W'(SETUP_CYC - 1);
    localparam logic [TIMER_W-1:0] PULSE_LOAD = TIMER_W'(PULSE_CYCLES - 1);
    localparam logic [TIMER_W-1:0] HOLD_LOAD = TIMER_W'(DH_CYC - 1);
    localparam logic [TIMER_W-1:0] OES_LOAD = TIMER_W'(OES_CYC - 1);
    localparam logic [TIMER_W-1:0] READ_LOAD = TIMER_W'(READ_CYC - 1);
    localparam logic [TIMER_W-1:0] DFP_LOAD = TIMER_W'(DFP_CYC - 1);
    localparam logic [TIMER_W-1:0] VPS_LOAD = TIMER_W'(VPS_CYC - 1);
    localparam logic [TIMER_W-1:0] VCS_LOAD = TIMER_W'(VCS_CYC - 1);
    localparam logic [TIMER_W-1:0] AS_LOAD = TIMER_W'(AS_CYC - 1);

    state_e state, next_state;
    logic [TIMER_W-1:0] timer, next_timer;
    otp_pins_s next_pins;
    prog_status_s next_status;
    logic [WORD_W-1:0] word, next_word;
    logic matched, next_matched;
    logic [WORD_W-1:0] next_id_code;
    logic next_id_valid;
    logic next_id_match;
    logic [WORD_W-1:0] rom_meta;
    logic [WORD_W-1:0] rom_sync;
    logic fifo_valid;
    logic [WORD_W-1:0] fifo_data;

    // ----------------------------------------------------------------------
    // image buffer: lets the source run ahead of the slow pulse sequence
    // ----------------------------------------------------------------------
    wire fifo_take = (state == S_FETCH) && (timer == '0);

    word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) image_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(src_valid),
        .in_data(src_data),
        .in_ready(src_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_take)
    );

    // ----------------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------------
    wire timer_done = (timer == '0);
    wire last_addr = ({1'b0, pins.addr} == CNT_W'(word_count - 1'b1));
    wire [ADDR_W-1:0] addr_inc = pins.addr + 1'b1;
    wire word_ok = (rom_sync == word);
    wire out_of_retries = (status.retries == MAX_RETRIES);
    wire [ADDR_W-1:0] id_addr = ADDR_W'(id_sel) << LOW_ADDR_BIT;

    // data pins come from another domain; two stages before any compare
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rom_meta <= '0;
            rom_sync <= '0;
        end else begin
            rom_meta <= rom_data;
            rom_sync <= rom_meta;
        end
    end

    // ----------------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_timer = timer_done ? timer : timer - 1'b1;
        next_pins = pins;
        next_status = status;
        next_status.done = 1'b0;
        next_word = word;
        next_matched = matched;
        next_id_code = id_code;
        next_id_valid = 1'b0;
        next_id_match = id_match;
        unique case (state)
            S_IDLE: begin
                if (start && word_count != '0) begin
                    next_pins.addr = '0;
                    next_pins.core_supply_high = 1'b1;
                    next_status = STATUS_RESET;
                    next_status.busy = 1'b1;
                    next_timer = VCS_LOAD;
                    next_state = S_CORE_UP;
                end else if (id_start) begin
                    next_pins.addr = id_addr;
                    next_pins.id_voltage_on = 1'b1;
                    next_status.busy = 1'b1;
                    next_timer = AS_LOAD;
                    next_state = S_ID_SETUP;
                end
            end
            S_CORE_UP: begin
                // core supply must be up before the program supply rises
                if (timer_done) begin
                    next_pins.prog_supply_high = 1'b1;
                    next_timer = VPS_LOAD;
                    next_state = S_FETCH;
                end
            end
            S_FETCH: begin
                if (timer_done && fifo_valid) begin
                    next_word = fifo_data;
                    if (status.phase == PASS_PROGRAM) begin
                        next_pins.data = fifo_data;
                        next_pins.data_oe_n = 1'b0;
                        next_timer = SETUP_LOAD;
                        next_state = S_SETUP;
                    end else begin
                        next_timer = OES_LOAD;
                        next_state = S_READ_SETUP;
                    end
                end
            end
            S_SETUP: begin
                if (timer_done) begin
                    next_pins.chip_select_n = 1'b0;
                    next_timer = PULSE_LOAD;
                    next_state = S_PULSE;
                end
            end
            S_PULSE: begin
                if (timer_done) begin
                    next_pins.chip_select_n = 1'b1;
                    next_timer = HOLD_LOAD;
                    next_state = S_HOLD;
                end
            end
            S_HOLD: begin
                if (timer_done) begin
                    next_pins.data_oe_n = 1'b1;
                    if (status.phase == PASS_PROGRAM) begin
                        // one pulse per address, no read in this pass
                        if (last_addr) begin
                            next_pins.addr = '0;
                            next_status.phase = PASS_VERIFY;
                        end else begin
                            next_pins.addr = addr_inc;
                        end
                        next_state = S_FETCH;
                    end else begin
                        next_timer = OES_LOAD;
                        next_state = S_READ_SETUP;
                    end
                end
            end
            S_READ_SETUP: begin
                if (timer_done) begin
                    next_pins.output_gate_n = 1'b0;
                    next_timer = READ_LOAD;
                    next_state = S_READ;
                end
            end
            S_READ: begin
                if (timer_done) begin
                    next_matched = word_ok;
                    next_pins.output_gate_n = 1'b1;
                    // wait for the ROM to float before driving data again
                    next_timer = DFP_LOAD;
                    next_state = S_FLOAT;
                end
            end
            S_FLOAT: begin
                if (timer_done) begin
                    if (!matched) begin
                        next_status.fail_addr = pins.addr;
                        if (status.phase == PASS_FINAL) begin
                            next_status.failed = 1'b1;
                            next_status.busy = 1'b0;
                            next_status.done = 1'b1;
                            next_state = S_IDLE;
                        end else if (out_of_retries) begin
                            next_status.failed = 1'b1;
                            next_pins.prog_supply_high = 1'b0;
                            next_timer = VPS_LOAD;
                            next_state = S_VPP_DOWN;
                        end else begin
                            next_status.retries = status.retries + 1'b1;
                            next_pins.data = word;
                            next_pins.data_oe_n = 1'b0;
                            next_timer = SETUP_LOAD;
                            next_state = S_SETUP;
                        end
                    end else if (!last_addr) begin
                        next_status.retries = '0;
                        next_pins.addr = addr_inc;
                        next_state = S_FETCH;
                    end else if (status.phase == PASS_FINAL) begin
                        next_status.passed = 1'b1;
                        next_status.busy = 1'b0;
                        next_status.done = 1'b1;
                        next_state = S_IDLE;
                    end else begin
                        // program supply falls first, then the core
                        next_pins.prog_supply_high = 1'b0;
                        next_timer = VPS_LOAD;
                        next_state = S_VPP_DOWN;
                    end
                end
            end
            S_VPP_DOWN: begin
                if (timer_done) begin
                    next_pins.core_supply_high = 1'b0;
                    next_timer = VCS_LOAD;
                    next_state = S_CORE_DOWN;
                end
            end
            S_CORE_DOWN: begin
                if (timer_done) begin
                    if (status.failed) begin
                        next_status.busy = 1'b0;
                        next_status.done = 1'b1;
                        next_state = S_IDLE;
                    end else begin
                        next_pins.addr = '0;
                        next_status.phase = PASS_FINAL;
                        next_state = S_FETCH;
                    end
                end
            end
            S_ID_SETUP: begin
                if (timer_done) begin
                    next_pins.output_gate_n = 1'b0;
                    next_timer = READ_LOAD;
                    next_state = S_ID_READ;
                end
            end
            S_ID_READ: begin
                if (timer_done) begin
                    next_id_code = rom_sync;
                    next_id_match = (rom_sync[15:8] == rom_sync[7:0]);
                    next_id_valid = 1'b1;
                    next_pins.output_gate_n = 1'b1;
                    next_timer = DFP_LOAD;
                    next_state = S_ID_END;
                end
            end
            S_ID_END: begin
                if (timer_done) begin
                    next_pins.id_voltage_on = 1'b0;
                    next_pins.addr = '0;
                    next_status.busy = 1'b0;
                    next_state = S_IDLE;
                end
            end
        endcase
    end

    // state registers; all ROM pins and status leave from here
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= S_IDLE;
            timer <= '0;
            pins <= PINS_RESET;
            status <= STATUS_RESET;
            word <= '0;
            matched <= 1'b0;
            id_code <= '0;
            id_valid <= 1'b0;
            id_match <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            pins <= next_pins;
            status <= next_status;
            word <= next_word;
            matched <= next_matched;
            id_code <= next_id_code;
            id_valid <= next_id_valid;
            id_match <= next_id_match;
        end
    end

endmodule : otp_programmer

`default_nettype wire

/* verif/otp_programmer_monitor.sv */
/* port checker for otp_programmer; assumes one clock, PULSE_CYCLES handed on by the bind */
`default_nettype none
module otp_programmer_monitor
    import otp_prog_pkg::*;
#(parameter int unsigned PULSE_CYCLES = 20) (
    input wire logic clk, // core clock
    input wire logic reset, // async, high
    input wire otp_pins_s pins, // rom pins
    input wire prog_status_s status, // progress
    input wire logic id_valid // id strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned low_cnt;
    // pulse length in a counter: far beyond any repetition count
    always_ff @(posedge clk or posedge reset)
        if (reset) low_cnt <= 0;
        else low_cnt <= pins.chip_select_n ? 0 : low_cnt + 1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_hold;
        (!pins.data_oe_n && $stable(pins.data)) [*8];
    endsequence
    property p_len; $rose(pins.chip_select_n) |-> low_cnt == PULSE_CYCLES; endproperty
    a_len: assert property (p_len) else $error("pulse length wrong");
    property p_max; low_cnt <= PULSE_CYCLES; endproperty
    a_max: assert property (p_max) else $error("pulse too long");
    property p_supply; !pins.chip_select_n |-> pins.core_supply_high && pins.prog_supply_high;
    endproperty
    a_supply: assert property (p_supply) else $error("pulse without supplies");
    property p_core_first; $rose(pins.prog_supply_high) |-> $past(pins.core_supply_high);
    endproperty
    a_core_first: assert property (p_core_first) else $error("program supply first");
    property p_drive; !pins.chip_select_n |-> pins.output_gate_n && !pins.data_oe_n
        && $stable(pins.addr); endproperty
    a_drive: assert property (p_drive) else $error("pins wrong in pulse");
    property p_hold; $rose(pins.chip_select_n) |-> s_hold; endproperty
    a_hold: assert property (p_hold) else $error("data not held");
    property p_release; !pins.output_gate_n |-> pins.data_oe_n; endproperty
    a_release: assert property (p_release) else $error("data driven in read");
    property p_lower; $fell(pins.core_supply_high) |-> !pins.prog_supply_high; endproperty
    a_lower: assert property (p_lower) else $error("core lowered first");
    property p_retry; status.retries <= MAX_RETRIES; endproperty
    a_retry: assert property (p_retry) else $error("too many retries");
    property p_id; id_valid |-> pins.id_voltage_on && pins.chip_select_n; endproperty
    a_id: assert property (p_id) else $error("id read without id voltage");
endmodule : otp_programmer_monitor
bind otp_programmer otp_programmer_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) mon_u (.clk(clk),
    .reset(reset), .pins(pins), .status(status), .id_valid(id_valid));
`default_nettype wire

/* verif/otp_rom_model.sv */
/* behavioural otp rom of 8 words; assumes the bench sets need[] before a run */
`default_nettype none
module otp_rom_model
    import otp_prog_pkg::*;
#(parameter logic [7:0] MAKER = 8'h00, parameter logic [7:0] KIND = 8'h00) (
    input wire logic clk, // core clock
    input wire otp_pins_s pins, // programmer pins
    output logic [WORD_W-1:0] rom_data // data pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WORD_W-1:0] mem [8];
    logic [WORD_W-1:0] last;
    int pcnt [8];
    int need [8];
    wire logic [7:0] code = pins.addr[LOW_ADDR_BIT] ? KIND : MAKER;
    wire logic [WORD_W-1:0] val = pins.id_voltage_on ? {code, code} : mem[pins.addr[2:0]];
    // a floating bus shows the inverse of its last value, never a stale match
    assign rom_data = pins.output_gate_n ? ~last : val;
    task automatic clear();
        for (int i = 0; i < 8; i++) begin
            mem[i] = '1;
            pcnt[i] = 0;
            need[i] = 0;
        end
        last = '0;
    endtask : clear
    initial clear();
    always @(posedge clk)
        if (!pins.output_gate_n) last <= val;
    // a word takes only after need[] extra pulses, to exercise the retry loop
    always @(posedge pins.chip_select_n)
        if (pins.core_supply_high === 1'b1 && pins.prog_supply_high === 1'b1) begin
            pcnt[pins.addr[2:0]]++;
            if (pcnt[pins.addr[2:0]] > need[pins.addr[2:0]]) mem[pins.addr[2:0]] = pins.data;
        end
endmodule : otp_rom_model
`default_nettype wire

/* verif/tb_top.sv */
/* bench for otp_programmer and a rom model; assumes package and design compiled first */
`default_nettype none
module tb_top
    import otp_prog_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MAKER_CODE = 8'h5A; // arbitrary
    localparam logic [7:0] KIND_CODE = 8'hC3; // arbitrary
    logic clk = 1'b0, reset = 1'b1, start = 1'b0, id_start = 1'b0, id_sel = 1'b0;
    logic src_valid = 1'b0, src_ready, id_valid, id_match;
    logic [CNT_W-1:0] word_count = '0;
    logic [WORD_W-1:0] src_data = '0, rom_data, id_code;
    logic [WORD_W-1:0] img [3] = '{16'h1234, 16'h00F0, 16'hA55A};
    otp_pins_s pins;
    prog_status_s status;
    int error_cnt = 0, cmp_count = 0;
    always #2 clk = ~clk;
    otp_programmer #(.PULSE_CYCLES(20)) dut_u (.clk(clk), .reset(reset), .start(start),
        .word_count(word_count), .id_start(id_start), .id_sel(id_sel), .src_valid(src_valid),
        .src_data(src_data), .src_ready(src_ready), .rom_data(rom_data), .pins(pins),
        .status(status), .id_code(id_code), .id_valid(id_valid), .id_match(id_match));
    otp_rom_model #(.MAKER(MAKER_CODE), .KIND(KIND_CODE)) rom_u (.clk(clk), .pins(pins),
        .rom_data(rom_data));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    // the image goes in three times: program, verify and final pass
    task automatic feed(input int n);
        for (int p = 0; p < 3; p++) for (int i = 0; i < n; i++) begin
            src_valid <= 1'b1;
            src_data <= img[i];
            do @(posedge clk); while (src_ready !== 1'b1);
        end
        src_valid <= 1'b0;
    endtask : feed
    task automatic run(input int n);
        start <= 1'b1;
        word_count <= n[CNT_W-1:0];
        @(posedge clk);
        start <= 1'b0;
        fork feed(n); join_none
        for (int c = 0; c < 60000 && status.done !== 1'b1; c++) @(posedge clk);
        disable fork;
        src_valid <= 1'b0;
        check(status.done, 1);
    endtask : run
    task automatic t_id();
        for (int s = 0; s < 2; s++) begin
            id_sel <= s[0];
            id_start <= 1'b1;
            @(posedge clk);
            id_start <= 1'b0;
            for (int c = 0; c < 600 && id_valid !== 1'b1; c++) @(posedge clk);
            check(id_code, s ? {2{KIND_CODE}} : {2{MAKER_CODE}});
            check(id_match, 1);
            repeat (40) @(posedge clk);
        end
    endtask : t_id
    task automatic t_ok();
        rom_u.need = '{0, 10, 2, 0, 0, 0, 0, 0};
        run(3);
        check(status.passed, 1);
        check(pins.prog_supply_high, 0);
        check(rom_u.pcnt[0], 1);
        check(rom_u.pcnt[1], 11);
        check(rom_u.pcnt[2], 3);
    endtask : t_ok
    task automatic t_fail();
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rom_u.clear();
        rom_u.need[1] = 11;
        @(posedge clk);
        run(3);
        check(status.failed, 1);
        check(status.fail_addr, 1);
        check(status.retries, 10);
        check(rom_u.pcnt[1], 11);
        check(rom_u.pcnt[2], 1);
    endtask : t_fail
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_id();
        t_ok();
        t_fail();
        wrap_up();
    end
    // both runs together need about 50k cycles
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
